// File: inc/trigger_router_defines.svh
// Register offsets, field positions and reset values for the trigger router.
// Assumes inclusion by bare name from the package; the modules use its macros without including it.
`ifndef TRIGGER_ROUTER_DEFINES_SVH
`define TRIGGER_ROUTER_DEFINES_SVH

// ====================================================================
// Register byte offsets
`define OFS_ENCODER_ROUTE   12'h000
`define OFS_FRAME_ROUTE     12'h004
`define OFS_SYNC_ROUTE      12'h008
`define OFS_TEST_OUTPUT     12'h00C
`define OFS_STATUS          12'h010

// ====================================================================
// Encoder route select fields
`define ENC_A_CC            0
`define ENC_B_CC            1
`define ENC_A_DIFF          2
`define ENC_B_DIFF          3
`define ENC_A_PIN           4
`define ENC_B_PIN           5
`define ENC_GATE_LOW        6
`define ENC_GATE_HIGH       7
`define ENC_GATE_CC2        8
`define ENC_GATE_CC4        9
`define ENC_A_INVERT        11
`define ENC_A_LOW           12
`define ENC_B_LOW           13
`define ENC_A_HIGH          14
`define ENC_B_HIGH          15

// ====================================================================
// Frame trigger and sync role route select fields
`define FRM_CC3             0
`define FRM_CC4             1
`define FRM_DIFF0           2
`define FRM_DIFF1           3
`define FRM_PIN             7
`define SYNC_MASTER_PIN     0
`define SYNC_MASTER_CC4     1
`define SYNC_PAIR_A         11
`define SYNC_PAIR_B         12

// ====================================================================
// Reset values
`define ENCODER_ROUTE_RESET 16'h2081
`define FRAME_ROUTE_RESET   16'h0001
`define SYNC_ROUTE_RESET    16'h0800
`define TEST_OUTPUT_RESET   16'h0000

`endif

// File: inc/trigger_router_pkg.sv
// Types shared by the trigger router modules.
// Assumes the defines header sits on the include path.
package trigger_router_pkg;
  `include "trigger_router_defines.svh"

  typedef logic [15:0] route_word_t;

  typedef enum logic [1:0] {
    access_idle,
    access_wait,
    access_done
  } access_state_t;
endpackage : trigger_router_pkg

// File: inc/route_cfg_if.sv
// Carries the select words from the register file to the routing core.
// Assumes one clock domain; all fields are registered by the producer.
`timescale 1ns/1ps
interface route_cfg_if;
  import trigger_router_pkg::*;
  route_word_t encoder_route;
  route_word_t frame_route;
  route_word_t sync_route;

  modport producer (output encoder_route, output frame_route, output sync_route);
  modport consumer (input encoder_route, input frame_route, input sync_route);
endinterface : route_cfg_if

// File: logic/input_synchroniser.sv
// Two-stage synchroniser bank for asynchronous pins.
// Assumes the inputs change freely with respect to pclk.
`timescale 1ns/1ps
module input_synchroniser #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // ====================================================================
  // Per-bit chain; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta[i]     <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule : input_synchroniser

// File: logic/route_core.sv
// Selects encoder, gate, frame trigger and master role sources from select words.
// Assumes synchronised inputs and well-formed one-hot selections.
`timescale 1ns/1ps
module route_core
  import trigger_router_pkg::*;
(
  route_cfg_if.consumer cfg,
  input  wire logic     cc1,
  input  wire logic     cc2,
  input  wire logic     cc3,
  input  wire logic     cc4,
  input  wire logic     diff_zero,
  input  wire logic     diff_one,
  input  wire logic     pin_two,
  input  wire logic     pin_two_n,
  input  wire logic     pin_four,
  output logic          raw_phase_a,
  output logic          raw_phase_b,
  output logic          raw_gate,
  output logic          raw_frame,
  output logic          raw_master_n
);
  route_word_t e;
  route_word_t f;
  route_word_t s;
  logic        a_src;

  assign e = cfg.encoder_route;
  assign f = cfg.frame_route;
  assign s = cfg.sync_route;

  // ====================================================================
  // Source selection; forced phase levels and forced gate low beat pin sources, forced gate high loses to CC2/CC4
  always_comb
  begin
    a_src = 1'b0;
    if (e[`ENC_A_HIGH])
      a_src = 1'b1;
    else if (e[`ENC_A_LOW])
      a_src = 1'b0;
    else if (e[`ENC_A_CC])
      a_src = cc1;
    else if (e[`ENC_A_DIFF])
      a_src = diff_zero;
    else if (e[`ENC_A_PIN])
      a_src = pin_two;
    raw_phase_a = a_src ^ e[`ENC_A_INVERT];

    raw_phase_b = 1'b0;
    if (e[`ENC_B_HIGH])
      raw_phase_b = 1'b1;
    else if (e[`ENC_B_LOW])
      raw_phase_b = 1'b0;
    else if (e[`ENC_B_CC])
      raw_phase_b = cc2;
    else if (e[`ENC_B_DIFF])
      raw_phase_b = diff_one;
    else if (e[`ENC_B_PIN])
      raw_phase_b = pin_two_n;

    // Forced low wins so software can always stop the encoder
    raw_gate = 1'b0;
    if (e[`ENC_GATE_LOW])
      raw_gate = 1'b0;
    else if (e[`ENC_GATE_CC4])
      raw_gate = cc4;
    else if (e[`ENC_GATE_CC2])
      raw_gate = cc2;
    else if (e[`ENC_GATE_HIGH])
      raw_gate = 1'b1;

    raw_frame = 1'b0;
    if (f[`FRM_CC3])
      raw_frame = cc3;
    else if (f[`FRM_CC4])
      raw_frame = cc4;
    else if (f[`FRM_DIFF0])
      raw_frame = diff_zero;
    else if (f[`FRM_DIFF1])
      raw_frame = diff_one;
    else if (f[`FRM_PIN])
      raw_frame = pin_four;

    raw_master_n = 1'b1;
    if (s[`SYNC_MASTER_PIN])
      raw_master_n = pin_four;
    else if (s[`SYNC_MASTER_CC4])
      raw_master_n = cc4;
  end
endmodule : route_core

// File: logic/line_scan_trigger_input_router.sv
// Top of the trigger input router: APB registers, synchronisers, routing, gating.
// Assumes one 50 MHz clock pclk, async active-low presetn, APB3 master.
//
// Notes on behaviour
// - An external control line can gate encoder inputs at run time.
// - Phase A source: CC1 bit 0, diff pair bit 2, single pin bit 4.
// - Select bit 12 forces phase A low, bit 14 forces it high.
// - Phase B source: CC2 bit 1, diff pair bit 3, single pin bit 5.
// - Bit 13 forces phase B low (default), bit 15 forces it high.
// - Gate forced off by bit 6, on by bit 7, or follows CC2/CC4.
// - Bit 11 inverts phase A before internal use.
// - Frame trigger from CC3, CC4, diff pairs or single pin per select bits.
// - Sync link placed on pin pair A (bit 11) or pair B (bit 12).
`timescale 1ns/1ps
module line_scan_trigger_input_router
  import trigger_router_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cc1,
  input  wire logic        cc2,
  input  wire logic        cc3,
  input  wire logic        cc4,
  input  wire logic        aux_diff_pair_zero,
  input  wire logic        aux_diff_pair_one,
  input  wire logic        aux_single_pin_two,
  input  wire logic        aux_single_pin_two_n,
  input  wire logic        aux_single_pin_four,
  input  wire logic        sync_in_pair_a,
  input  wire logic        sync_in_pair_b,
  output logic             sync_out_pair_a,
  output logic             sync_out_pair_b,
  output logic             sync_oe_pair_a,
  output logic             sync_oe_pair_b,
  output logic             encoder_phase_a,
  output logic             encoder_phase_b,
  output logic             encoder_gate,
  output logic             line_trigger_pulse,
  output logic             encoder_b_pulse,
  output logic             frame_trigger_inputs,
  output logic             master_role_select_n,
  output logic             camera_sync_link_in,
  output logic [15:0]      test_output_select
);
  localparam int N_IN = 11;

  route_cfg_if cfg ();

  route_word_t encoder_route;
  route_word_t frame_route;
  route_word_t sync_route;
  logic [N_IN-1:0] pins_sync;
  logic raw_phase_a;
  logic raw_phase_b;
  logic raw_gate;
  logic raw_frame;
  logic raw_master_n;
  logic prev_a;
  logic prev_b;
  logic next_link_out;
  logic link_in;

  assign cfg.encoder_route = encoder_route;
  assign cfg.frame_route   = frame_route;
  assign cfg.sync_route    = sync_route;

  // ====================================================================
  // APB register file; zero wait states
  logic setup;
  logic wr;
  logic rd;
  logic known;
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;
  assign rd    = setup && !pwrite;
  always_comb
  begin
    unique case (paddr)
      `OFS_ENCODER_ROUTE,
      `OFS_FRAME_ROUTE,
      `OFS_SYNC_ROUTE,
      `OFS_TEST_OUTPUT,
      `OFS_STATUS:        known = 1'b1;
      default:            known = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      encoder_route      <= `ENCODER_ROUTE_RESET;
      frame_route        <= `FRAME_ROUTE_RESET;
      sync_route         <= `SYNC_ROUTE_RESET;
      test_output_select <= `TEST_OUTPUT_RESET;
    end
    else if (wr)
    begin
      unique case (paddr)
        `OFS_ENCODER_ROUTE: encoder_route      <= pwdata[15:0];
        `OFS_FRAME_ROUTE:   frame_route        <= pwdata[15:0];
        `OFS_SYNC_ROUTE:    sync_route         <= pwdata[15:0];
        `OFS_TEST_OUTPUT:   test_output_select <= pwdata[15:0];
        default:            ;
      endcase
    end
  end

  // Read data is captured in setup so it stands during the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (paddr)
        `OFS_ENCODER_ROUTE: prdata <= {16'h0000, encoder_route};
        `OFS_FRAME_ROUTE:   prdata <= {16'h0000, frame_route};
        `OFS_SYNC_ROUTE:    prdata <= {16'h0000, sync_route};
        `OFS_TEST_OUTPUT:   prdata <= {16'h0000, test_output_select};
        `OFS_STATUS:        prdata <= {16'h0000, 5'b0_0000, pins_sync};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !known;
    end
  end

  // ====================================================================
  // Pin synchronisers
  input_synchroniser #(
    .WIDTH (N_IN)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({sync_in_pair_b, sync_in_pair_a, aux_single_pin_four,
                aux_single_pin_two_n, aux_single_pin_two, aux_diff_pair_one,
                aux_diff_pair_zero, cc4, cc3, cc2, cc1}),
    .sync_out (pins_sync)
  );

  // ====================================================================
  // Routing
  route_core u_core (
    .cfg          (cfg.consumer),
    .cc1          (pins_sync[0]),
    .cc2          (pins_sync[1]),
    .cc3          (pins_sync[2]),
    .cc4          (pins_sync[3]),
    .diff_zero    (pins_sync[4]),
    .diff_one     (pins_sync[5]),
    .pin_two      (pins_sync[6]),
    .pin_two_n    (pins_sync[7]),
    .pin_four     (pins_sync[8]),
    .raw_phase_a  (raw_phase_a),
    .raw_phase_b  (raw_phase_b),
    .raw_gate     (raw_gate),
    .raw_frame    (raw_frame),
    .raw_master_n (raw_master_n)
  );

  // ====================================================================
  // Registered routed levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      encoder_phase_a      <= 1'b0;
      encoder_phase_b      <= 1'b0;
      encoder_gate         <= 1'b0;
      frame_trigger_inputs <= 1'b0;
      master_role_select_n <= 1'b1;
    end
    else
    begin
      encoder_phase_a      <= raw_phase_a;
      encoder_phase_b      <= raw_phase_b;
      encoder_gate         <= raw_gate;
      frame_trigger_inputs <= raw_frame;
      master_role_select_n <= raw_master_n;
    end
  end

  // ====================================================================
  // Gated edge detection; edge history still tracks while gated off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_a             <= 1'b0;
      prev_b             <= 1'b0;
      line_trigger_pulse <= 1'b0;
      encoder_b_pulse    <= 1'b0;
    end
    else
    begin
      prev_a             <= encoder_phase_a;
      prev_b             <= encoder_phase_b;
      line_trigger_pulse <= encoder_gate && encoder_phase_a && !prev_a;
      encoder_b_pulse    <= encoder_gate && encoder_phase_b && !prev_b;
    end
  end

  // ====================================================================
  // Sync link pin pair; master drives, slave listens
  always_comb
  begin
    next_link_out = encoder_phase_a;
    link_in       = 1'b0;
    if (sync_route[`SYNC_PAIR_A])
      link_in = pins_sync[9];
    else if (sync_route[`SYNC_PAIR_B])
      link_in = pins_sync[10];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_out_pair_a     <= 1'b0;
      sync_out_pair_b     <= 1'b0;
      sync_oe_pair_a      <= 1'b0;
      sync_oe_pair_b      <= 1'b0;
      camera_sync_link_in <= 1'b0;
    end
    else
    begin
      sync_out_pair_a     <= next_link_out;
      sync_out_pair_b     <= next_link_out;
      sync_oe_pair_a      <= !master_role_select_n && sync_route[`SYNC_PAIR_A];
      sync_oe_pair_b      <= !master_role_select_n && !sync_route[`SYNC_PAIR_A]
                             && sync_route[`SYNC_PAIR_B];
      camera_sync_link_in <= link_in;
    end
  end

  // ====================================================================
  // Checks
  a_gate_blocks_lines: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(encoder_gate) |-> !line_trigger_pulse)
    else $error("line trigger advanced while gate inactive");
  a_gate_blocks_b: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(encoder_gate) |-> !encoder_b_pulse)
    else $error("phase b pulse while gate inactive");
  a_force_a_high: assert property (@(posedge pclk) disable iff (!presetn)
    (encoder_route[`ENC_A_HIGH] && !encoder_route[`ENC_A_INVERT])
      [*2] |=> encoder_phase_a)
    else $error("phase a not forced high");
  a_force_b_low: assert property (@(posedge pclk) disable iff (!presetn)
    (encoder_route[`ENC_B_LOW] && !encoder_route[`ENC_B_HIGH]) [*2] |=> !encoder_phase_b)
    else $error("phase b not forced low");
  a_gate_forced_off: assert property (@(posedge pclk) disable iff (!presetn)
    encoder_route[`ENC_GATE_LOW] [*2] |=> !encoder_gate)
    else $error("gate not forced inactive");
  a_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
    (encoder_route[`ENC_A_LOW] && !encoder_route[`ENC_A_HIGH]
      && encoder_route[`ENC_A_INVERT]) [*2] |=> encoder_phase_a)
    else $error("inverted forced low not high");
  // Pin to level: two synchroniser stages plus the output flop
  a_phase_a_cc1: assert property (@(posedge pclk) disable iff (!presetn)
    (encoder_route[`ENC_A_CC] && !encoder_route[`ENC_A_HIGH] && !encoder_route[`ENC_A_LOW]
      && !encoder_route[`ENC_A_INVERT]) [*4]
      |-> encoder_phase_a == $past(cc1, 3))
    else $error("phase a does not follow cc1");
  a_frame_cc3: assert property (@(posedge pclk) disable iff (!presetn)
    frame_route == 16'h0001 [*4] |-> frame_trigger_inputs == $past(cc3, 3))
    else $error("frame trigger does not follow cc3");
  a_pair_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    !(sync_oe_pair_a && sync_oe_pair_b))
    else $error("both sync pairs driven");
endmodule : line_scan_trigger_input_router

// File: sim/pin_source_model.sv
// Far side of the router: control lines, encoders, sensors, remote camera.
// Assumes the bench changes want by non-blocking assignment after a pclk edge.
`timescale 1ns/1ps
module pin_source_model (
  input  wire logic [9:0] want,
  input  wire logic       sync_out_pair_a,
  input  wire logic       sync_out_pair_b,
  input  wire logic       sync_oe_pair_a,
  input  wire logic       sync_oe_pair_b,
  output logic            cc1,
  output logic            cc2,
  output logic            cc3,
  output logic            cc4,
  output logic            aux_diff_pair_zero,
  output logic            aux_diff_pair_one,
  output logic            aux_single_pin_two,
  output logic            aux_single_pin_two_n,
  output logic            aux_single_pin_four,
  output logic            sync_in_pair_a,
  output logic            sync_in_pair_b
);
  // ====================================================================
  // Pin levels
  assign {aux_single_pin_four, aux_single_pin_two_n, aux_single_pin_two} = want[8:6];
  assign {aux_diff_pair_one, aux_diff_pair_zero, cc4, cc3, cc2, cc1} = want[5:0];
  // Remote camera drives a pair only while this camera leaves it free
  assign sync_in_pair_a = sync_oe_pair_a ? sync_out_pair_a : want[9];
  assign sync_in_pair_b = sync_oe_pair_b ? sync_out_pair_b : want[9];
endmodule : pin_source_model

// File: sim/test_line_scan_trigger_input_router.sv
// Self-checking bench for the trigger input router.
// Assumes the design files, the package and the far-side model are compiled first.
`timescale 1ns/1ps
module test_line_scan_trigger_input_router;
  import trigger_router_pkg::*;
  typedef struct packed {
    logic [15:0] enc;
    logic [15:0] frm;
    logic [15:0] syn;
    logic [9:0]  pin;
    logic [7:0]  exp;
  } row_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0]  want = 10'h000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic        cc1, cc2, cc3, cc4, aux_diff_pair_zero, aux_diff_pair_one;
  logic        aux_single_pin_two, aux_single_pin_two_n, aux_single_pin_four;
  logic        sync_in_pair_a, sync_in_pair_b, sync_out_pair_a, sync_out_pair_b;
  logic        sync_oe_pair_a, sync_oe_pair_b, encoder_phase_a, encoder_phase_b;
  logic        encoder_gate, line_trigger_pulse, encoder_b_pulse, frame_trigger_inputs;
  logic        master_role_select_n, camera_sync_link_in;
  logic [15:0] test_output_select;
  int          n_fail = 0;
  int          num_checks = 0;
  int          n_lt = 0;
  int          n_b = 0;
  int          p, q;
  logic [31:0] rst_v [4] = '{32'h0000_2081, 32'h0000_0001, 32'h0000_0800, 32'h0000_0000};
  // Expected: {phase a, phase b, gate, frame, master_n, oe a, oe b, link in}
  row_t rows [25] = '{
    {16'h2081, 16'h0001, 16'h0800, 10'h001, 8'hA8},
    {16'h2084, 16'h0001, 16'h0800, 10'h010, 8'hA8},
    {16'h2090, 16'h0001, 16'h0800, 10'h040, 8'hA8},
    {16'h3080, 16'h0001, 16'h0800, 10'h001, 8'h28},
    {16'h6080, 16'h0001, 16'h0800, 10'h000, 8'hA8},
    {16'h0083, 16'h0001, 16'h0800, 10'h002, 8'h68},
    {16'h0089, 16'h0001, 16'h0800, 10'h020, 8'h68},
    {16'h00A1, 16'h0001, 16'h0800, 10'h080, 8'h68},
    {16'h8081, 16'h0001, 16'h0800, 10'h000, 8'h68},
    {16'h2881, 16'h0001, 16'h0800, 10'h000, 8'hA8},
    {16'h2041, 16'h0001, 16'h0800, 10'h001, 8'h88},
    {16'h2101, 16'h0001, 16'h0800, 10'h002, 8'h28},
    {16'h2101, 16'h0001, 16'h0800, 10'h000, 8'h08},
    {16'h2201, 16'h0001, 16'h0800, 10'h008, 8'h28},
    {16'h2201, 16'h0001, 16'h0800, 10'h002, 8'h08},
    {16'h2081, 16'h0001, 16'h0800, 10'h004, 8'h38},
    {16'h2081, 16'h0002, 16'h0800, 10'h008, 8'h38},
    {16'h2081, 16'h0004, 16'h0800, 10'h010, 8'h38},
    {16'h2081, 16'h0008, 16'h0800, 10'h020, 8'h38},
    {16'h2081, 16'h0080, 16'h0800, 10'h100, 8'h38},
    {16'h2081, 16'h0001, 16'h0801, 10'h001, 8'hA5},
    {16'h2081, 16'h0001, 16'h1001, 10'h001, 8'hA3},
    {16'h2081, 16'h0001, 16'h0800, 10'h200, 8'h29},
    {16'h3880, 16'h0001, 16'h0800, 10'h000, 8'hA8},
    {16'h2081, 16'h0001, 16'h0802, 10'h000, 8'h24}
  };

  line_scan_trigger_input_router dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cc1, .cc2, .cc3, .cc4, .aux_diff_pair_zero, .aux_diff_pair_one,
    .aux_single_pin_two, .aux_single_pin_two_n, .aux_single_pin_four,
    .sync_in_pair_a, .sync_in_pair_b, .sync_out_pair_a, .sync_out_pair_b,
    .sync_oe_pair_a, .sync_oe_pair_b, .encoder_phase_a, .encoder_phase_b,
    .encoder_gate, .line_trigger_pulse, .encoder_b_pulse, .frame_trigger_inputs,
    .master_role_select_n, .camera_sync_link_in, .test_output_select
  );

  pin_source_model far_u (
    .want, .sync_out_pair_a, .sync_out_pair_b, .sync_oe_pair_a, .sync_oe_pair_b,
    .cc1, .cc2, .cc3, .cc4, .aux_diff_pair_zero, .aux_diff_pair_one,
    .aux_single_pin_two, .aux_single_pin_two_n, .aux_single_pin_four,
    .sync_in_pair_a, .sync_in_pair_b
  );

  // ====================================================================
  // Clock, pulse counters, watchdog
  initial
  begin
    forever #10 pclk = ~pclk;
  end

  // Non-blocking so the main sequence reads a stable count at an edge
  always @(posedge pclk)
  begin
    if (line_trigger_pulse === 1'b1) n_lt <= n_lt + 1;
    if (encoder_b_pulse === 1'b1) n_b <= n_b + 1;
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    final_report();
  end

  // ====================================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Called just after a rising edge; returns one edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ====================================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      chk("reset value", rst_v[i], rd);
    end
    apb(1'b1, 12'h00C, 32'hFFFF_1234);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("test select", 32'h0000_1234, rd);
    chk("test output", 16'h1234, test_output_select);
    apb(1'b1, 12'h014, 32'h0000_5555);
    chk("unmapped write err", 1'b1, err);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped read err", 32'h0000_0001, {31'h0000_0000, err});
    chk("unmapped read", 32'h0000_0000, rd);
    want <= 10'h3FF;
    repeat (4) @(posedge pclk);
    apb(1'b1, 12'h010, 32'h0000_0000);
    chk("status write err", 1'b0, err);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("synced pins", 32'h0000_07FF, rd);
    foreach (rows[i])
    begin
      apb(1'b1, 12'h000, {16'h0000, rows[i].enc});
      apb(1'b1, 12'h004, {16'h0000, rows[i].frm});
      apb(1'b1, 12'h008, {16'h0000, rows[i].syn});
      want <= rows[i].pin;
      repeat (8) @(posedge pclk);
      #1;
      chk("routed levels", rows[i].exp, {encoder_phase_a, encoder_phase_b, encoder_gate,
          frame_trigger_inputs, master_role_select_n, sync_oe_pair_a, sync_oe_pair_b,
          camera_sync_link_in});
      @(posedge pclk);
    end
    // Latency through the synchroniser, then one gated pulse
    apb(1'b1, 12'h000, 32'h0000_0083);
    want <= 10'h000;
    repeat (6) @(posedge pclk);
    want <= 10'h001;
    repeat (2) @(posedge pclk);
    #1 chk("phase a early", 1'b0, encoder_phase_a);
    @(posedge pclk);
    #1 chk("phase a", 1'b1, encoder_phase_a);
    @(posedge pclk);
    #1 chk("line pulse", 1'b1, line_trigger_pulse);
    @(posedge pclk);
    #1 chk("line pulse end", 1'b0, line_trigger_pulse);
    @(posedge pclk);
    q = n_b;
    want <= 10'h003;
    repeat (8) @(posedge pclk);
    chk("b pulses open", 32'd1, 32'(n_b - q));
    apb(1'b1, 12'h000, 32'h0000_0043);
    want <= 10'h000;
    repeat (6) @(posedge pclk);
    p = n_lt;
    q = n_b;
    want <= 10'h003;
    repeat (8) @(posedge pclk);
    chk("pulses gated", 32'd0, 32'((n_lt - p) + (n_b - q)));
    // Second reset in mid-run; pins quiet so no stale level crosses it
    want    <= 10'h000;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("encoder select after reset", 32'h0000_2081, rd);
    final_report();
  end
endmodule : test_line_scan_trigger_input_router
